// file: pkg/flash_sect_pkg.sv
`default_nettype none
package flash_sect_pkg;
   localparam int unsigned ADDR_W = 15;
   localparam int unsigned WB_AW  = 4;

   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_IRQ_ST = 4'h8;
   localparam logic [3:0] REG_IRQ_EN = 4'hC;

   localparam int unsigned CTRL_BUSY_CLR  = 0;
   localparam int unsigned CTRL_LOCK_WR   = 1;
   localparam int unsigned CTRL_LOCK_POS  = 4;
   localparam int unsigned CTRL_CHIP_ERASE = 8;

   localparam int unsigned ST_BUSY   = 0;
   localparam int unsigned ST_HALT   = 1;
   localparam int unsigned ST_ACTIVE = 2;
   localparam int unsigned ST_LOCK_POS = 4;
   localparam int unsigned ST_FUSE_POS = 8;

   localparam int unsigned IRQ_DONE   = 0;
   localparam int unsigned IRQ_REJECT = 1;
   localparam int unsigned IRQ_W      = 2;

   localparam logic [ADDR_W-1:0] HALT_START = 15'h7000;
   localparam logic [ADDR_W-1:0] BOOT_START_00 = 15'h7000;
   localparam logic [ADDR_W-1:0] BOOT_START_01 = 15'h7800;
   localparam logic [ADDR_W-1:0] BOOT_START_10 = 15'h7C00;
   localparam logic [ADDR_W-1:0] BOOT_START_11 = 15'h7E00;

   localparam logic [3:0] LOCK_RESET = 4'hF;
   localparam logic [1:0] LOCK_MODE1 = 2'h3;
   localparam logic [1:0] LOCK_MODE2 = 2'h2;
   localparam logic [1:0] LOCK_MODE3 = 2'h0;

   localparam real OP_TIME_NS = 4000.0;
   localparam real CLK_NS     = 5.0;
   localparam int unsigned OP_CYCLES = int'($ceil(OP_TIME_NS / CLK_NS));
endpackage
`default_nettype wire

// file: pkg/flash_op_if.sv
`default_nettype none
interface flash_op_if;
   logic                              start;
   logic [flash_sect_pkg::ADDR_W-1:0] addr;
   logic                              done;
   logic                              busy;
   modport ctrl  (output start, output addr, input done, input busy);
   modport timer (input start, input addr, output done, output busy);
endinterface
`default_nettype wire

// file: logic/flash_op_timer.sv
`default_nettype none
module flash_op_timer (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   flash_op_if.timer        op
);
   logic [12:0] cnt_r;
   logic        run_r;
   logic        last_w;

   assign last_w  = run_r && (cnt_r == 13'h0001);
   assign op.done = last_w;
   assign op.busy = run_r;

   // a new start is only accepted while idle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_r <= 1'b0;
         cnt_r <= 13'h0000;
      end else if (!run_r && op.start) begin
         run_r <= 1'b1;
         cnt_r <= 13'(flash_sect_pkg::OP_CYCLES);
      end else if (last_w) begin
         run_r <= 1'b0;
         cnt_r <= 13'h0000;
      end else if (run_r) begin
         cnt_r <= cnt_r - 13'h0001;
      end
   end
endmodule
`default_nettype wire

// file: logic/flash_self_program_sections.sv
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`default_nettype none
module flash_self_program_sections (
   input  wire logic                              clk_i,
   input  wire logic                              rst_i,
   input  wire logic [1:0]                        boot_size_fuses_i,
   input  wire logic                              store_program_instruction_i,
   input  wire logic [flash_sect_pkg::ADDR_W-1:0] exec_addr_i,
   input  wire logic [flash_sect_pkg::ADDR_W-1:0] target_addr_i,
   output logic                                   spm_ack_o,
   output logic                                   cpu_halt_o,
   output logic                                   flash_start_o,
   output logic [flash_sect_pkg::ADDR_W-1:0]      flash_addr_o,
   input  wire logic [flash_sect_pkg::WB_AW-1:0]  wb_adr_i,
   input  wire logic [31:0]                       wb_dat_i,
   output logic [31:0]                            wb_dat_o,
   input  wire logic [3:0]                        wb_sel_i,
   input  wire logic                              wb_we_i,
   input  wire logic                              wb_cyc_i,
   input  wire logic                              wb_stb_i,
   output logic                                   wb_ack_o,
   output logic                                   irq_o
);
   typedef enum logic [2:0] {
      IDLE = 3'b001,
      PROG = 3'b010,
      DONE = 3'b100
   } state_t;

   state_t state_r;
   state_t state_nxt;

   flash_op_if op ();

   flash_op_timer timer_u (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .op    (op)
   );

   logic [1:0]                        fuse_s1_r;
   logic [1:0]                        fuse_s2_r;
   logic [3:0]                        lock_r;
   logic                              busy_r;
   logic                              halt_r;
   logic [flash_sect_pkg::ADDR_W-1:0] addr_r;
   logic                              ack_r;
   logic [flash_sect_pkg::IRQ_W-1:0]  irq_st_r;
   logic [flash_sect_pkg::IRQ_W-1:0]  irq_en_r;
   logic                              wb_ack_r;
   logic [31:0]                       wb_dat_r;

   function automatic logic [flash_sect_pkg::ADDR_W-1:0] boot_start(input logic [1:0] f);
      logic [flash_sect_pkg::ADDR_W-1:0] s;
      s = flash_sect_pkg::BOOT_START_11;
      unique case (f)
         2'h0: s = flash_sect_pkg::BOOT_START_00;
         2'h1: s = flash_sect_pkg::BOOT_START_01;
         2'h2: s = flash_sect_pkg::BOOT_START_10;
         2'h3: s = flash_sect_pkg::BOOT_START_11;
      endcase
      return s;
   endfunction

   // a lock pair forbids writes in modes two and three
   function automatic logic write_locked(input logic [1:0] pair);
      return (pair == flash_sect_pkg::LOCK_MODE2) || (pair == flash_sect_pkg::LOCK_MODE3);
   endfunction

   // section membership is a lower bound; every section here runs to the flash end
   function automatic logic at_or_above(input logic [flash_sect_pkg::ADDR_W-1:0] a,
                                        input logic [flash_sect_pkg::ADDR_W-1:0] base);
      return a >= base;
   endfunction

   // fuse pins are straps outside the clock domain
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fuse_s1_r <= 2'h0;
      end else begin
         fuse_s1_r <= boot_size_fuses_i;
      end
   end

   // only the second stage feeds the section decode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fuse_s2_r <= 2'h0;
      end else begin
         fuse_s2_r <= fuse_s1_r;
      end
   end

   wire [flash_sect_pkg::ADDR_W-1:0] boot_base_w = boot_start(fuse_s2_r);
   // every boot start sits at or above the halting boundary
   wire exec_in_boot_w   = at_or_above(exec_addr_i, boot_base_w);
   wire target_in_boot_w = at_or_above(target_addr_i, boot_base_w);
   wire target_halts_w   = at_or_above(target_addr_i, flash_sect_pkg::HALT_START);
   wire [1:0] app_lock_w  = lock_r[1:0];
   wire [1:0] boot_lock_w = lock_r[3:2];
   // application pair in mode one never blocks
   wire lock_block_w = target_in_boot_w ? write_locked(boot_lock_w)
                                        : write_locked(app_lock_w);
   // the answer edge still sees the held request; it must not be taken twice
   wire req_w    = store_program_instruction_i && (state_r == IDLE) && !ack_r;
   // any page may be targeted from boot; no address range
   wire accept_w = req_w && exec_in_boot_w && !lock_block_w;
   wire reject_w = req_w && !accept_w;

   wire wb_req_w = wb_cyc_i && wb_stb_i && !wb_ack_r;
   wire wb_wr_w  = wb_req_w && wb_we_i;
   wire wr_ctrl_w = wb_wr_w && (wb_adr_i == flash_sect_pkg::REG_CTRL) && wb_sel_i[0];
   wire wr_ctrl1_w = wb_wr_w && (wb_adr_i == flash_sect_pkg::REG_CTRL) && wb_sel_i[1];
   wire wr_iclr_w = wb_wr_w && (wb_adr_i == flash_sect_pkg::REG_IRQ_ST) && wb_sel_i[0];
   wire wr_ien_w  = wb_wr_w && (wb_adr_i == flash_sect_pkg::REG_IRQ_EN) && wb_sel_i[0];
   wire busy_clr_w = wr_ctrl_w && wb_dat_i[flash_sect_pkg::CTRL_BUSY_CLR];
   wire lock_wr_w  = wr_ctrl_w && wb_dat_i[flash_sect_pkg::CTRL_LOCK_WR];
   wire chip_erase_w = wr_ctrl1_w && wb_dat_i[flash_sect_pkg::CTRL_CHIP_ERASE];
   wire [3:0] lock_val_w = wb_dat_i[flash_sect_pkg::CTRL_LOCK_POS +: 4];
   wire [flash_sect_pkg::IRQ_W-1:0] irq_clr_w =
      wr_iclr_w ? wb_dat_i[flash_sect_pkg::IRQ_W-1:0] : '0;
   wire [flash_sect_pkg::IRQ_W-1:0] irq_set_w = {reject_w, op.done};

   wire [31:0] status_w = {20'h00000, 2'h0, fuse_s2_r,
                           lock_r, 1'b0, (state_r != IDLE), halt_r, busy_r};
   wire [31:0] rd_mux_w =
      (wb_adr_i == flash_sect_pkg::REG_STATUS) ? status_w :
      (wb_adr_i == flash_sect_pkg::REG_IRQ_ST) ? {30'h00000000, irq_st_r} :
      (wb_adr_i == flash_sect_pkg::REG_IRQ_EN) ? {30'h00000000, irq_en_r} :
      (wb_adr_i == flash_sect_pkg::REG_CTRL)   ? {24'h000000, lock_r, 4'h0} :
      32'h00000000;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         IDLE: begin
            if (accept_w) begin
               state_nxt = PROG;
            end
         end
         PROG: begin
            if (op.done) begin
               state_nxt = DONE;
            end
         end
         // one cycle to answer before a new request may be taken
         DONE: begin
            state_nxt = IDLE;
         end
      endcase
   end

   assign op.start = (state_r == IDLE) && accept_w;
   assign op.addr  = target_addr_i;

   // next values of every register but the fuse stages, so each flop process stays a plain copy
   logic                              prog_w;
   logic                              ack_nxt;
   logic [flash_sect_pkg::ADDR_W-1:0] addr_nxt;
   logic                              halt_nxt;
   logic                              busy_nxt;
   logic [3:0]                        lock_nxt;
   logic [flash_sect_pkg::IRQ_W-1:0]  irq_st_nxt;
   logic [flash_sect_pkg::IRQ_W-1:0]  irq_en_nxt;
   logic                              wb_ack_nxt;
   logic [31:0]                       wb_dat_nxt;

   assign prog_w   = (state_r == PROG);
   // rejects answer on the cycle after the request; accepted work answers on the cycle after done
   assign ack_nxt  = reject_w || (prog_w && op.done);
   // address is latched at accept, so the core may move its pointer on
   assign addr_nxt = accept_w ? target_addr_i : addr_r;
   // halt follows the programmed target, not whatever the core reads
   assign halt_nxt = accept_w ? target_halts_w :
                     op.done  ? 1'b0 :
                     halt_r;

   // busy set wins over a software clear landing in the same cycle
   assign busy_nxt = (accept_w && !target_halts_w) ? 1'b1 :
                     (busy_clr_w && !op.busy)      ? 1'b0 :
                     busy_r;

   // locks only move toward programmed; chip erase restores
   assign lock_nxt = chip_erase_w ? flash_sect_pkg::LOCK_RESET :
                     lock_wr_w    ? (lock_r & lock_val_w) :
                     lock_r;

   // event set wins over a write-one clear in the same cycle
   assign irq_st_nxt = (irq_st_r & ~irq_clr_w) | irq_set_w;
   assign irq_en_nxt = wr_ien_w ? wb_dat_i[flash_sect_pkg::IRQ_W-1:0] : irq_en_r;
   assign wb_ack_nxt = wb_req_w;
   // read data is zero outside an answer, so a stale word never lingers
   assign wb_dat_nxt = (wb_req_w && !wb_we_i) ? rd_mux_w : 32'h00000000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= ack_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_r <= '0;
      end else begin
         addr_r <= addr_nxt;
      end
   end

   // reset releases the core at once, even in the middle of an operation
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         halt_r <= 1'b0;
      end else begin
         halt_r <= halt_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= busy_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_r <= flash_sect_pkg::LOCK_RESET;
      end else begin
         lock_r <= lock_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_st_r <= '0;
      end else begin
         irq_st_r <= irq_st_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_en_r <= '0;
      end else begin
         irq_en_r <= irq_en_nxt;
      end
   end

   // ack comes one cycle after the request and drops the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_r <= 1'b0;
      end else begin
         wb_ack_r <= wb_ack_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_r <= 32'h00000000;
      end else begin
         wb_dat_r <= wb_dat_nxt;
      end
   end

   assign wb_ack_o      = wb_ack_r;
   assign wb_dat_o      = wb_dat_r;
   assign irq_o         = |(irq_st_r & irq_en_r);
   assign spm_ack_o     = ack_r;
   assign cpu_halt_o    = halt_r;
   assign flash_start_o = op.start;
   assign flash_addr_o  = addr_r;
endmodule
`default_nettype wire

// file: sim/flash_sect_properties.sv
`default_nettype none
module flash_sect_properties (
   input wire logic                              clk_i,
   input wire logic                              rst_i,
   input wire logic                              store_program_instruction_i,
   input wire logic [flash_sect_pkg::ADDR_W-1:0] exec_addr_i,
   input wire logic [flash_sect_pkg::ADDR_W-1:0] target_addr_i,
   input wire logic                              spm_ack_o,
   input wire logic                              cpu_halt_o,
   input wire logic                              flash_start_o,
   input wire logic [flash_sect_pkg::ADDR_W-1:0] flash_addr_o,
   input wire logic                              wb_cyc_i,
   input wire logic                              wb_stb_i,
   input wire logic                              wb_ack_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // boot never reaches below the halting start, whatever the fuses
   wire logic in_halt = exec_addr_i >= flash_sect_pkg::HALT_START;
   wire logic tgt_halt = target_addr_i >= flash_sect_pkg::HALT_START;
   property p_start_boot;
      flash_start_o |-> store_program_instruction_i && in_halt;
   endproperty
   a_start_boot: assert property (p_start_boot) else $error("start off boot");
   property p_app_reject;
      $rose(store_program_instruction_i) && !in_halt |=> spm_ack_o && !cpu_halt_o;
   endproperty
   a_app_reject: assert property (p_app_reject) else $error("no quick reject");
   property p_addr;
      flash_start_o |=> flash_addr_o == $past(target_addr_i);
   endproperty
   a_addr: assert property (p_addr) else $error("target not latched");
   property p_halt_halting_section;
      flash_start_o && tgt_halt |=> cpu_halt_o;
   endproperty
   a_halt_halting_section: assert property (p_halt_halting_section) else $error("no halt");
   property p_no_halt;
      flash_start_o && !tgt_halt |=> !cpu_halt_o [*2];
   endproperty
   a_no_halt: assert property (p_no_halt) else $error("halted on rww");
   property p_halt_hold;
      cpu_halt_o && !spm_ack_o |=> cpu_halt_o || spm_ack_o;
   endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("halt dropped early");
   property p_wb_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_wb_ack: assert property (p_wb_ack) else $error("bus ack late");
   property p_wb_drop;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_wb_drop: assert property (p_wb_drop) else $error("bus ack stuck");
endmodule
`default_nettype wire

// file: sim/cpu_core_model.sv
`default_nettype none
module cpu_core_model (
   input  wire logic                              clk_i,
   input  wire logic                              ack_i,
   output logic                                   req_o,
   output logic [flash_sect_pkg::ADDR_W-1:0]      exec_o,
   output logic [flash_sect_pkg::ADDR_W-1:0]      tgt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int lat = 0;
   initial begin
      req_o = 1'b0;
      exec_o = '0;
      tgt_o = '0;
   end
   task automatic issue(input logic [flash_sect_pkg::ADDR_W-1:0] ex, tg, input int gap);
      repeat (gap) @(posedge clk_i);
      req_o <= 1'b1;
      exec_o <= ex;
      tgt_o <= tg;
      lat = -1;
      for (int n = 1; n < 2000 && lat < 0; n++) begin
         @(posedge clk_i);
         if (ack_i === 1'b1) lat = n;
      end
      // no fetch or vector use while the op runs; released lines toggle
      req_o <= 1'b0;
      exec_o <= ~ex;
      tgt_o <= ~tg;
   endtask
endmodule
`default_nettype wire

// file: sim/flash_self_program_sections_test.sv
`default_nettype none
module flash_self_program_sections_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0]  CT = flash_sect_pkg::REG_CTRL;
   localparam logic [3:0]  ST = flash_sect_pkg::REG_STATUS;
   localparam logic [3:0]  IS = flash_sect_pkg::REG_IRQ_ST;
   localparam logic [3:0]  IE = flash_sect_pkg::REG_IRQ_EN;
   localparam logic [31:0] ACC = 32'(flash_sect_pkg::OP_CYCLES + 2);
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [1:0]  fuse = 2'h3;
   logic        req, ack, halt, start, irq, wack;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [14:0] ex, tg, faddr;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wdat = '0, rdat, d;
   int          err_total = 0;
   int          n_checks = 0;
   always #2.5 clk_i = ~clk_i;
   flash_self_program_sections flash_self_program_sections_i (
      .clk_i, .rst_i, .boot_size_fuses_i(fuse), .store_program_instruction_i(req),
      .exec_addr_i(ex), .target_addr_i(tg), .spm_ack_o(ack), .cpu_halt_o(halt),
      .flash_start_o(start), .flash_addr_o(faddr), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_ack_o(wack), .irq_o(irq));
   cpu_core_model cpu_core_model_i (.clk_i, .ack_i(ack), .req_o(req), .exec_o(ex), .tgt_o(tg));
   task automatic final_report(input bit hung);
      if (hung) err_total++;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] v);
      int n;
      n = 0;
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, v};
      do begin
         @(posedge clk_i);
         n++;
      end while (wack !== 1'b1 && n < 20);
      if (wack !== 1'b1) final_report(1'b1);
      d = rdat;
      {cyc, stb} <= 2'b00;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
      wb(a, 1'b0, 32'h0);
      chk(d, exp, what);
   endtask
   task automatic lat_is(input logic [31:0] exp, input string what);
      chk(32'(cpu_core_model_i.lat), exp, what);
   endtask
   task automatic op_during(input logic [14:0] t, input logic [31:0] m, exp);
      fork
         cpu_core_model_i.issue(15'h7F00, t, 3);
         begin
            repeat (20) @(posedge clk_i);
            wb(ST, 1'b0, 32'h0);
            chk(d & m, exp, "status mid op");
            chk({31'h0, halt}, {31'h0, exp[1]}, "halt pin");
         end
      join
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rd(ST, 32'h3F0, "status reset");
      rd(CT, 32'hF0, "locks reset");
      rd(4'h2, 32'h0, "unmapped");
      wb(IE, 1'b1, 32'h3);
      $display("test 1 done");
      // fuse 3: 0x7100 is halting section yet application code
      for (int i = 0; i < 2; i++) begin
         cpu_core_model_i.issue(i ? 15'h7100 : 15'h0100, 15'h0400, i);
         lat_is(32'd2, "app issue");
      end
      rd(IS, 32'h2, "reject flag");
      chk({31'h0, irq}, 32'h1, "irq up");
      rd(ST, 32'h3F0, "no busy");
      wb(IE, 1'b1, 32'h0);
      chk({31'h0, irq}, 32'h0, "irq masked");
      wb(IS, 1'b1, 32'h2);
      rd(IS, 32'h0, "irq cleared");
      wb(IE, 1'b1, 32'h3);
      $display("test 2 done");
      op_during(15'h0400, 32'h7, 32'h5);
      lat_is(ACC, "rww op");
      chk({17'h0, faddr}, 32'h0400, "flash addr");
      rd(ST, 32'h3F1, "busy kept");
      wb(CT, 1'b1, 32'h1);
      rd(ST, 32'h3F0, "busy cleared");
      rd(IS, 32'h1, "done flag");
      wb(IS, 1'b1, 32'h1);
      $display("test 3 done");
      op_during(15'h7E40, 32'h6, 32'h6);
      lat_is(ACC, "boot self op");
      chk({17'h0, faddr}, 32'h7E40, "boot addr");
      wb(CT, 1'b1, 32'h1);
      $display("test 4 done");
      wb(CT, 1'b1, 32'hB2);
      rd(CT, 32'hB0, "locks set");
      cpu_core_model_i.issue(15'h7F00, 15'h7E40, 0);
      lat_is(32'd2, "boot mode 2");
      cpu_core_model_i.issue(15'h7F00, 15'h0400, 1);
      lat_is(ACC, "app mode 1");
      wb(CT, 1'b1, 32'h1);
      wb(CT, 1'b1, 32'hF2);
      rd(CT, 32'hB0, "locks sticky");
      wb(CT, 1'b1, 32'h100);
      rd(CT, 32'hF0, "chip erase");
      wb(CT, 1'b1, 32'hC2);
      cpu_core_model_i.issue(15'h7F00, 15'h0400, 0);
      lat_is(32'd2, "app mode 3");
      wb(CT, 1'b1, 32'h32);
      cpu_core_model_i.issue(15'h7F00, 15'h7E40, 2);
      lat_is(32'd2, "boot mode 3");
      rd(ST, 32'h300, "no busy locked");
      $display("test 5 done");
      final_report(1'b0);
   end
endmodule
bind flash_self_program_sections flash_sect_properties flash_sect_properties_i (
   .clk_i, .rst_i, .store_program_instruction_i, .exec_addr_i, .target_addr_i,
   .spm_ack_o, .cpu_halt_o, .flash_start_o, .flash_addr_o, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o);
`default_nettype wire
